// [verilog/prio_bank_regs.vh]
/*
 * Register offsets, field positions and reset values for the
 * interrupt priority bank. Assumes an AXI4-Lite byte address.
 */
`ifndef PRIO_BANK_REGS_VH
`define PRIO_BANK_REGS_VH

// Byte offsets of the seven priority registers
`define PB_OFS_TIMER2_CMP2_CAP2   5'h00
`define PB_OFS_URX_SPI_TIMER3     5'h04
`define PB_OFS_ADC_UTX            5'h08
`define PB_OFS_CHG_CMP_I2C        5'h0C
`define PB_OFS_EXT1               5'h10
`define PB_OFS_TIMER4             5'h14
`define PB_OFS_EXT2_TIMER5        5'h18
// Arbitration result (read only)
`define PB_OFS_RESULT             5'h1C

// Field low-bit positions inside a 16-bit register
`define PB_POS_HI                 12
`define PB_POS_MH                 8
`define PB_POS_ML                 4
`define PB_POS_LO                 0

// Field reset pattern: level 4
`define PB_FIELD_RST              3'h4
`define PB_FIELD_OFF              3'h0

// Number of priority sources in the bank
`define PB_NUM_SRC                17

// AXI response codes
`define PB_RESP_OKAY              2'h0
`define PB_RESP_SLVERR            2'h2

`endif

// [verilog/prio_field.v]
/*
 * One 3-bit priority field: storage with reset to level 4 and
 * qualification of its pending request.
 * Assumes write strobe and data are synchronous to sys_clk_i.
 */
`timescale 1ns/1ps
`include "prio_bank_regs.vh"

module prio_field #(
    parameter PRESENT = 1
) (
    input  wire       sys_clk_i,
    input  wire       arst_n_i,
    input  wire       clk_en_i,
    input  wire       wr_i,
    input  wire [2:0] wdata_i,
    input  wire       req_i,
    output wire [2:0] prio_o,
    output wire       live_o
);

    reg [2:0] prio_r;

    // Stored level; writes apply at the next edge
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prio_r <= `PB_FIELD_RST;                          // [RULE_03] [RULE_14]
        end else if (clk_en_i && wr_i) begin
            prio_r <= wdata_i;                                // [RULE_05] [RULE_16]
        end
    end

    // Absent fields read zero so they can never win arbitration
    assign prio_o = (PRESENT != 0) ? prio_r : `PB_FIELD_OFF;  // [RULE_13]
    // Level zero masks the request entirely
    assign live_o = req_i && (prio_o != `PB_FIELD_OFF);       // [RULE_02]

endmodule // prio_field

// [verilog/prio_arbiter.v]
/*
 * Combinational winner selection over all qualified sources.
 * Assumes levels and live flags are stable register outputs.
 */
`timescale 1ns/1ps

module prio_arbiter #(
    parameter N = 17
) (
    input  wire [3*N-1:0] level_i,
    input  wire [N-1:0]   live_i,
    output reg  [2:0]     win_level_o,
    output reg  [4:0]     win_index_o,
    output reg            win_valid_o
);

    integer k;

    // Strict greater-than keeps the lowest index on ties
    always @* begin
        win_level_o = 3'h0;
        win_index_o = 5'h00;
        win_valid_o = 1'b0;
        for (k = 0; k < N; k = k + 1) begin
            if (live_i[k] && (level_i[3*k +: 3] > win_level_o)) begin
                win_level_o = level_i[3*k +: 3];               // [RULE_15]
                win_index_o = k[4:0];
                win_valid_o = 1'b1;
            end
        end
    end

endmodule // prio_arbiter

// [verilog/prio_bank.v]
/*
 * Interrupt priority bank: seven 16-bit priority registers behind an
 * AXI4-Lite slave, plus arbitration of pending enabled sources.
 * Assumes the requesting peripherals present level requests already
 * gated by their enables, synchronous to sys_clk_i.
 */
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "prio_bank_regs.vh"

// Function
// [RULE_01] Three-bit field: 111 is seven, 001 one
// [RULE_02] Code 000 disables the source
// [RULE_03] Fields reset to pattern 100
// [RULE_04] Unimplemented bits read zero, ignore writes
// [RULE_05] Implemented bits read back last write
// [RULE_06] Register one: timer2, compare2, capture2
// [RULE_07] Register two: serial rx, spi, timer3
// [RULE_08] Register three: conversion, serial tx only
// [RULE_09] Register four: change, comparator, i2c pair
// [RULE_10] Register five: external one only
// [RULE_11] Register six: timer4 only
// [RULE_12] Register seven: external two, timer5
// [RULE_13] Timer4, timer5 only on large variants
// [RULE_14] After reset every source at level four
// [RULE_15] Highest level wins, ties by index
// [RULE_16] Write affects arbitration next cycle
module prio_bank #(
    parameter LARGE_MEM = 1
) (
    input  wire        sys_clk_i,
    input  wire        arst_n_i,
    input  wire        clk_en_i,
    // AXI4-Lite slave
    input  wire [4:0]  s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,
    output wire [1:0]  s_axi_bresp_o,
    output wire        s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    input  wire [4:0]  s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0]  s_axi_rresp_o,
    output wire        s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    // Sources and CPU side
    input  wire [16:0] src_req_i,
    output reg  [2:0]  cpu_level_o,
    output reg  [4:0]  cpu_source_o,
    output reg         cpu_req_o
);

    localparam N = `PB_NUM_SRC;

    ////////////////////////////////////////////////////////////////////////
    // Field map: register index and bit position per source index.
    // Source order: 0 timer2, 1 compare2, 2 capture2, 3 serial rx,
    // 4 spi event, 5 spi error, 6 timer3, 7 conversion, 8 serial tx,
    // 9 pin change, 10 comparator, 11 i2c master, 12 i2c slave,
    // 13 external one, 14 timer4, 15 external two, 16 timer5.
    ////////////////////////////////////////////////////////////////////////

    function [2:0] src_reg;
        input integer s;
        begin
            case (s)
                0, 1, 2:          src_reg = 3'h0;              // [RULE_06]
                3, 4, 5, 6:       src_reg = 3'h1;              // [RULE_07]
                7, 8:             src_reg = 3'h2;              // [RULE_08]
                9, 10, 11, 12:    src_reg = 3'h3;              // [RULE_09]
                13:               src_reg = 3'h4;              // [RULE_10]
                14:               src_reg = 3'h5;              // [RULE_11]
                default:          src_reg = 3'h6;              // [RULE_12]
            endcase
        end
    endfunction

    function integer src_pos;
        input integer s;
        begin
            case (s)
                0, 3, 9, 14:      src_pos = `PB_POS_HI;
                1, 4, 10:         src_pos = `PB_POS_MH;
                2, 5, 7, 11, 15:  src_pos = `PB_POS_ML;
                default:          src_pos = `PB_POS_LO;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path
    ////////////////////////////////////////////////////////////////////////

    reg        aw_full_r;
    reg [4:0]  aw_addr_r;
    reg        w_full_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;
    reg        bvalid_r;
    reg [1:0]  bresp_r;

    wire       wr_go;
    wire [2:0] wr_reg;
    wire       wr_hit;

    // Each channel holds one item; both must land before the write
    assign s_axi_awready_o = !aw_full_r && !bvalid_r;
    assign s_axi_wready_o  = !w_full_r && !bvalid_r;
    assign wr_go           = aw_full_r && w_full_r && !bvalid_r;
    assign wr_reg          = aw_addr_r[4:2];
    assign wr_hit          = (aw_addr_r < `PB_OFS_RESULT);

    // Capture address and data in either order, then answer
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 5'h00;
            w_full_r  <= 1'b0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `PB_RESP_OKAY;
        end else if (clk_en_i) begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata_i;
                w_strb_r <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? `PB_RESP_OKAY : `PB_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o  = bresp_r;

    ////////////////////////////////////////////////////////////////////////
    // Priority fields, one instance per source
    ////////////////////////////////////////////////////////////////////////

    wire [3*N-1:0] level_w;
    wire [N-1:0]   live_w;
    wire [N-1:0]   fwr_w;
    wire [3*N-1:0] fdata_w;

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_fld
            localparam [2:0] RIX = src_reg(g);
            localparam       POS = src_pos(g);
            // Byte lane holding the field must be strobed
            assign fwr_w[g] = wr_go && wr_hit && (wr_reg == RIX)
                              && w_strb_r[POS/8];
            assign fdata_w[3*g +: 3] = w_data_r[POS +: 3];
            prio_field #(
                .PRESENT (((g == 14) || (g == 16)) ? LARGE_MEM : 1)   // [RULE_13]
            ) u_fld (
                .sys_clk_i (sys_clk_i),
                .arst_n_i  (arst_n_i),
                .clk_en_i  (clk_en_i),
                .wr_i      (fwr_w[g]),
                .wdata_i   (fdata_w[3*g +: 3]),
                .req_i     (src_req_i[g]),
                .prio_o    (level_w[3*g +: 3]),
                .live_o    (live_w[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read image: only field bits are placed, the rest stay zero
    ////////////////////////////////////////////////////////////////////////

    reg [15:0] img [0:6];
    integer    s;
    integer    r;

    // Unmapped bits are never overwritten, so they read as zero
    always @* begin
        for (r = 0; r < 7; r = r + 1) begin
            img[r] = 16'h0000;                                 // [RULE_04]
        end
        for (s = 0; s < N; s = s + 1) begin
            img[src_reg(s)][src_pos(s) +: 3] = level_w[3*s +: 3];  // [RULE_05]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbitration and CPU-facing result
    ////////////////////////////////////////////////////////////////////////

    wire [2:0] win_level;
    wire [4:0] win_index;
    wire       win_valid;

    prio_arbiter #(
        .N (N)
    ) u_arb (
        .level_i     (level_w),
        .live_i      (live_w),
        .win_level_o (win_level),
        .win_index_o (win_index),
        .win_valid_o (win_valid)
    );

    // Registered so the CPU sees a stable word; levels 1..7 pass as coded
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cpu_level_o  <= 3'h0;
            cpu_source_o <= 5'h00;
            cpu_req_o    <= 1'b0;
        end else if (clk_en_i) begin
            cpu_level_o  <= win_level;                         // [RULE_01]
            cpu_source_o <= win_index;
            cpu_req_o    <= win_valid;                         // [RULE_02]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path
    ////////////////////////////////////////////////////////////////////////

    reg        rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0]  rresp_r;
    wire [2:0] rd_reg;

    assign s_axi_arready_o = !rvalid_r;
    assign rd_reg          = s_axi_araddr_i[4:2];

    // One-cycle answer; result word carries the winner for software
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= `PB_RESP_OKAY;
        end else if (clk_en_i) begin
            if (s_axi_arvalid_i && !rvalid_r) begin
                rvalid_r <= 1'b1;
                rresp_r  <= `PB_RESP_OKAY;
                if (s_axi_araddr_i == `PB_OFS_RESULT) begin
                    rdata_r <= {23'h000000, cpu_req_o, cpu_source_o, cpu_level_o};
                end else if (rd_reg < 3'h7) begin
                    rdata_r <= {16'h0000, img[rd_reg]};
                end else begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= `PB_RESP_SLVERR;
                end
            end else if (rvalid_r && s_axi_rready_i) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o  = rdata_r;
    assign s_axi_rresp_o  = rresp_r;

endmodule // prio_bank

// [sim/prio_bank_properties.sv]
/* Checker for the priority bank: bus answers and arbitration outputs.
   Assumes one clock domain with clk_en_i held high. */
`timescale 1ns/1ps
module prio_bank_props (
    input wire        sys_clk_i,
    input wire        arst_n_i,
    input wire        s_axi_awvalid_i,
    input wire        s_axi_awready_o,
    input wire        s_axi_wvalid_i,
    input wire        s_axi_wready_o,
    input wire        s_axi_bvalid_o,
    input wire        s_axi_arvalid_i,
    input wire        s_axi_arready_o,
    input wire        s_axi_rvalid_o,
    input wire [31:0] s_axi_rdata_o,
    input wire [16:0] src_req_i,
    input wire [2:0]  cpu_level_o,
    input wire        cpu_req_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    a_b_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken during response");
    a_r_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken during response");
    a_rdata_unimpl: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:15] == 17'h00000
        && !s_axi_rdata_o[11]) else $error("unused bits not zero");
    a_off_not_sent: assert property (cpu_req_o |-> cpu_level_o != 3'h0)
        else $error("level zero presented");
    a_idle_level: assert property (!cpu_req_o |-> cpu_level_o == 3'h0)
        else $error("level without request");
    a_idle_no_req: assert property (src_req_i == 17'h00000 |=> !cpu_req_o)
        else $error("request with no source");
    a_req_cause: assert property (cpu_req_o |-> $past(src_req_i) != 17'h00000)
        else $error("request without cause");
    c_write: cover property (s_axi_bvalid_o);
    c_read: cover property (s_axi_rvalid_o);
    c_cpu: cover property (cpu_req_o && cpu_level_o == 3'h7);
endmodule // prio_bank_props

bind prio_bank prio_bank_props u_props (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rdata_o(s_axi_rdata_o), .src_req_i(src_req_i), .cpu_level_o(cpu_level_o),
    .cpu_req_o(cpu_req_o));

// [sim/src_model.sv]
/* Requesting peripherals: level requests toward the bank.
   Assumes the bench changes the wanted pattern just after an edge. */
`timescale 1ns/1ps
module src_model (
    input  wire        sys_clk_i,
    input  wire        arst_n_i,
    input  wire [16:0] want_i,
    output reg  [16:0] req_o
);
    // Flag flop, so requests move only on the clock like real flags
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            req_o <= 17'h00000;
        else
            req_o <= want_i;
    end
endmodule // src_model

// [sim/prio_bank_test.sv]
/* Bench for the priority bank: register tasks over AXI4-Lite and
   arbitration checks. Assumes clk_en_i stays high throughout. */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module prio_bank_test;
    logic        clk = 0, arst_n = 0, awv = 0, wv = 0, arv = 0, bry = 1, rry = 1;
    logic [4:0]  awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h00000000;
    logic [3:0]  ws = 4'h0;
    logic [16:0] want = 17'h00000;
    wire  [16:0] req;
    wire  [31:0] rd;
    wire  [1:0]  brsp, rrsp;
    wire  [2:0]  lvl;
    wire  [4:0]  six;
    wire         awr, wr, bv, arr, rv, creq;
    int          bad_count = 0, total_checks = 0, i;
    // Reset values and writable masks, one entry per register
    logic [15:0] rstv [7] = '{16'h4440, 16'h4444, 16'h0044, 16'h4444, 16'h0004, 16'h4000, 16'h0044};
    logic [15:0] msk [7] = '{16'h7770, 16'h7777, 16'h0077, 16'h7777, 16'h0007, 16'h7000, 16'h0077};
    ////////////////////////////////////////
    prio_bank DUT (.sys_clk_i(clk), .arst_n_i(arst_n), .clk_en_i(1'b1), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(brsp), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rrsp), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rry), .src_req_i(req), .cpu_level_o(lvl), .cpu_source_o(six),
        .cpu_req_o(creq));
    src_model u_src (.sys_clk_i(clk), .arst_n_i(arst_n), .want_i(want), .req_o(req));
    initial begin
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////
    // Readies only move at rising edges, so the mid-cycle look equals the edge sample
    task automatic wr32(input [4:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        bit ta, tw, da, dw;
        da = 0;
        dw = 0;
        @(posedge clk);
        awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1;
        while (!(da && dw)) begin
            @(negedge clk); ta = awv && awr; tw = wv && wr;
            @(posedge clk);
            if (ta) begin awv <= 0; da = 1; end
            if (tw) begin wv <= 0; dw = 1; end
        end
        do begin @(negedge clk); ta = bv; if (ta) `CHK(brsp, er) @(posedge clk); end while (!ta);
    endtask
    task automatic rd32(input [4:0] a, input [31:0] e);
        bit t;
        @(posedge clk);
        ara <= a; arv <= 1;
        do begin @(negedge clk); t = arr; @(posedge clk); end while (!t);
        arv <= 0;
        do begin
            @(negedge clk);
            t = rv;
            if (t) begin `CHK(rd, e) `CHK(rrsp, 2'h0) end
            @(posedge clk);
        end while (!t);
    endtask
    task automatic rst_pulse;
        arst_n <= 0;
        repeat (5) @(posedge clk);
        arst_n <= 1;
    endtask
    task end_sim;
        if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        rst_pulse;
        for (i = 0; i < 7; i++) rd32(i * 4, {16'h0, rstv[i]});
        wr32(5'h00, 32'h00007777, 4'h1, 2'h0);
        rd32(5'h00, 32'h00004470);
        for (i = 0; i < 7; i++) begin
            wr32(i * 4, 32'hFFFFFFFF, 4'hF, 2'h0);
            rd32(i * 4, {16'h0, msk[i]});
        end
        wr32(5'h1C, 32'hFFFFFFFF, 4'hF, 2'h2);
        rst_pulse;
        rd32(5'h00, 32'h00004440);
        for (i = 0; i < 7; i++) wr32(i * 4, 32'h0, 4'hF, 2'h0);
        want <= 17'h1FFFF;
        repeat (3) @(posedge clk);
        @(negedge clk); `CHK(creq, 1'b0)
        wr32(5'h04, 32'h7, 4'hF, 2'h0);
        @(negedge clk); `CHK({creq, lvl, six}, {1'b1, 3'h7, 5'h06})
        wr32(5'h00, 32'h7000, 4'hF, 2'h0);
        @(negedge clk); `CHK({creq, lvl, six}, {1'b1, 3'h7, 5'h00})
        wr32(5'h00, 32'h0, 4'hF, 2'h0);
        wr32(5'h04, 32'h0, 4'hF, 2'h0);
        wr32(5'h08, 32'h10, 4'hF, 2'h0);
        @(negedge clk); `CHK({creq, lvl, six}, {1'b1, 3'h1, 5'h07})
        rd32(5'h1C, {23'h000000, 1'b1, 5'h07, 3'h1});
        end_sim;
    end
    // Whole run needs under two hundred cycles; far beyond that means a hang
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim;
    end
endmodule // prio_bank_test
